// [logic/prs_pkg.sv]
// shared constants and types of the pwm restart, dead-band and steering block
// assumes one 40 MHz clock that stands for the oscillator; synchronous reset
`default_nettype none
package prs_pkg;
    localparam int DW = 8;
    localparam int AW = 2;
    localparam int NPIN = 4;
    // register indices
    localparam logic [AW-1:0] REG_DEADBAND = 2'h0;
    localparam logic [AW-1:0] REG_STEER    = 2'h1;
    localparam logic [AW-1:0] REG_MODE     = 2'h2;
    localparam logic [AW-1:0] REG_STATUS   = 2'h3;
    // field positions
    localparam int RESTART_BIT = 7;
    localparam int DCNT_W      = 7;
    localparam int SYNC_BIT    = 4;
    localparam int FLAG_BIT    = 0;
    localparam int CFG_LSB     = 4;
    // reset values
    localparam logic [DW-1:0] DEADBAND_RST = 8'h00;
    localparam logic [DW-1:0] STEER_RST    = 8'h01;
    localparam logic [DW-1:0] MODE_RST     = 8'h00;
    // mode encodings
    localparam logic [1:0] MODE_PWM   = 2'h3;
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    // timing: one instruction cycle is four oscillator periods
    localparam int CLK_NS     = 25;
    localparam int INSTR_NS   = 100;
    localparam int INSTR_CLKS = INSTR_NS / CLK_NS;
    localparam int CNT_W      = 9;
    // dead-band sequencer states, gray along idle-wait-active
    typedef enum logic [1:0] {
        DB_IDLE   = 2'h0,
        DB_WAIT   = 2'h1,
        DB_ACTIVE = 2'h3
    } prs_db_state_t;
endpackage
`default_nettype wire

// [logic/prs_db_if.sv]
// link between the output stage and its dead-band delayer
// assumes both ends on the same clock
`timescale 1ns/100ps
`default_nettype none
interface prs_db_if;
    import prs_pkg::*;
    logic              raw;     // undelayed pwm, active high
    logic [DCNT_W-1:0] count;   // delay in instruction cycles
    logic              delayed; // pwm with delayed active edge
    modport src (output raw, output count, input delayed);
    modport dly (input raw, input count, output delayed);
endinterface
`default_nettype wire

// [logic/prs_deadband.sv]
// dead-band delayer: holds back the rising edge of the pwm
// assumes raw and count from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module prs_deadband
    import prs_pkg::*;
(
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    prs_db_if.dly     dif
);
    prs_db_state_t    state;
    logic [CNT_W-1:0] cnt;

    // sequencer: falling edge passes at once, rising edge waits
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            state <= DB_IDLE;
            cnt   <= '0;
        end
        else
        begin
            unique case (state)
                DB_IDLE:
                begin
                    if (dif.raw && dif.count == '0)
                        state <= DB_ACTIVE;
                    else if (dif.raw)
                    begin
                        state <= DB_WAIT;
                        cnt   <= CNT_W'(int'(dif.count) * INSTR_CLKS - 1);
                    end
                end
                DB_WAIT:
                begin
                    if (!dif.raw)
                        state <= DB_IDLE;
                    else if (cnt == '0)
                        state <= DB_ACTIVE;
                    else
                        cnt <= cnt - 1'b1;
                end
                DB_ACTIVE:
                begin
                    if (!dif.raw)
                        state <= DB_IDLE;
                end
                default:
                    state <= DB_IDLE;
            endcase
        end
    end

    assign dif.delayed = (state == DB_ACTIVE);

    a_zero_delay_edge: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        ($rose(dif.raw) && dif.count == 7'h00) |=> dif.delayed)
        else $error("zero delay did not pass edge next cycle");

    a_two_cycle_delay: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        ($rose(dif.raw) && dif.count == 7'h02) ##1 dif.raw[*8]
        |-> !$past(dif.delayed, 2) ##1 dif.delayed)
        else $error("delay of two instruction cycles wrong");

    a_fall_passes: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $fell(dif.raw) |=> !dif.delayed)
        else $error("inactive edge was delayed");

    c_delayed_edge: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(dif.delayed) && dif.count != 7'h00);
endmodule // prs_deadband
`default_nettype wire

// [logic/prs_top.sv]
// output stage of the enhanced pwm: restart, dead-band, pin steering
// assumes i_pwm_raw and i_period_start come from the pwm generator on
// i_ref_clk; i_shutdown comes from a pin or comparator and is synchronised
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module prs_top
    import prs_pkg::*;
(
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_rst,
    input  wire logic [prs_pkg::AW-1:0]  i_addr,
    input  wire logic [prs_pkg::DW-1:0]  i_wr_data,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    input  wire logic                    i_pwm_raw,
    input  wire logic                    i_period_start,
    input  wire logic                    i_shutdown,
    input  wire logic [prs_pkg::NPIN-1:0] i_port_data,
    input  wire logic [prs_pkg::NPIN-1:0] i_port_oe,
    output var  logic [prs_pkg::DW-1:0]  o_rd_data,
    output var  logic [prs_pkg::NPIN-1:0] o_pin_out,
    output var  logic [prs_pkg::NPIN-1:0] o_pin_oe,
    output var  logic                    o_shutdown_active
);
    import prs_pkg::*;

    // polarity of a pin: a and c from mode bit 1, b and d from bit 0
    function automatic logic pol_of(input logic [3:0] mode, input int idx);
        pol_of = (idx % 2 == 0) ? mode[1] : mode[0];
    endfunction

    // register contents
    logic              auto_restart;
    logic [DCNT_W-1:0] deadband_delay_count;
    logic              steer_update_sync;
    logic [NPIN-1:0]   steer_shadow;
    logic [NPIN-1:0]   steer_act;
    logic [3:0]        capture_compare_mode_select;
    logic [1:0]        pwm_output_config;
    logic              shutdown_event_flag;

    // internal
    logic       sd_meta;
    logic       sd_sync;
    logic [1:0] div;
    logic       tick;
    logic       pwm_mode;
    logic       steer_mode;
    logic       wave;
    logic       wr_status;
    logic       wr_steer;

    prs_db_if dbus ();

    // dead-band delayer on the raw waveform
    prs_deadband u_deadband (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .dif       (dbus.dly)
    );

    assign dbus.raw   = i_pwm_raw;
    assign dbus.count = deadband_delay_count;

    // two-flop synchroniser for the shutdown input
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            sd_meta <= 1'b0;
            sd_sync <= 1'b0;
        end
        else
        begin
            sd_meta <= i_shutdown;
            sd_sync <= sd_meta;
        end
    end

    // instruction-cycle enable, one pulse every four clocks
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            div  <= '0;
            tick <= 1'b0;
        end
        else
        begin
            div  <= (div == 2'(INSTR_CLKS - 1)) ? 2'h0 : 2'(div + 1'b1);
            tick <= (div == 2'(INSTR_CLKS - 1));
        end
    end

    // write decode
    assign wr_status = i_wr && (i_addr == REG_STATUS);
    assign wr_steer  = i_wr && (i_addr == REG_STEER);

    // restart and dead-band register
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            auto_restart         <= DEADBAND_RST[RESTART_BIT];
            deadband_delay_count <= DEADBAND_RST[DCNT_W-1:0];
        end
        else if (i_wr && i_addr == REG_DEADBAND)
        begin
            auto_restart         <= i_wr_data[RESTART_BIT];
            deadband_delay_count <= i_wr_data[DCNT_W-1:0];
        end
    end

    // steering register; bits 7:5 are not stored
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            steer_update_sync <= STEER_RST[SYNC_BIT];
            steer_shadow      <= STEER_RST[NPIN-1:0];
        end
        else if (wr_steer)
        begin
            steer_update_sync <= i_wr_data[SYNC_BIT];
            steer_shadow      <= i_wr_data[NPIN-1:0];
        end
    end

    // mode and output configuration register
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            capture_compare_mode_select <= MODE_RST[3:0];
            pwm_output_config           <= MODE_RST[CFG_LSB+1:CFG_LSB];
        end
        else if (i_wr && i_addr == REG_MODE)
        begin
            capture_compare_mode_select <= i_wr_data[3:0];
            pwm_output_config           <= i_wr_data[CFG_LSB+1:CFG_LSB];
        end
    end

    // live steering enables: at instruction boundary or at period start
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            steer_act <= STEER_RST[NPIN-1:0];
        else if (steer_update_sync ? i_period_start : tick)
            steer_act <= steer_shadow;
    end

    // shutdown flag: set wins over every clear
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            shutdown_event_flag <= 1'b0;
        else if (sd_sync)
            shutdown_event_flag <= 1'b1;
        else if (wr_status)
            shutdown_event_flag <= i_wr_data[FLAG_BIT];
        else if (auto_restart)
            shutdown_event_flag <= 1'b0;
    end

    // mode decode
    assign pwm_mode   = (capture_compare_mode_select[3:2] == MODE_PWM);
    assign steer_mode = pwm_mode && (pwm_output_config == CFG_SINGLE);
    assign wave       = dbus.delayed && !shutdown_event_flag;

    // per-pin mux: pwm with polarity, or hand the pin to the port
    for (genvar g = 0; g < NPIN; g++)
    begin : g_pin
        logic en;
        assign en = steer_mode ? steer_act[g] : (pwm_mode && g == 0);
        always_ff @(posedge i_ref_clk)
        begin
            if (i_rst)
            begin
                o_pin_out[g] <= 1'b0;
                o_pin_oe[g]  <= 1'b0;
            end
            else if (en)
            begin
                o_pin_out[g] <= wave ^ pol_of(capture_compare_mode_select, g);
                o_pin_oe[g]  <= 1'b1;
            end
            else
            begin
                o_pin_out[g] <= i_port_data[g];
                o_pin_oe[g]  <= i_port_oe[g];
            end
        end
    end

    // read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            o_rd_data <= '0;
        else if (i_rd)
        begin
            unique case (i_addr)
                REG_DEADBAND: o_rd_data <= {auto_restart, deadband_delay_count};
                REG_STEER:    o_rd_data <= {3'h0, steer_update_sync, steer_shadow};
                REG_MODE:     o_rd_data <= {2'h0, pwm_output_config,
                                            capture_compare_mode_select};
                REG_STATUS:   o_rd_data <= {7'h00, shutdown_event_flag};
            endcase
        end
        else
            o_rd_data <= '0;
    end

    // shutdown state to the outside
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            o_shutdown_active <= 1'b0;
        else
            o_shutdown_active <= shutdown_event_flag;
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_auto_clear_flag: assert property (
        (shutdown_event_flag && auto_restart && !sd_sync && !wr_status)
        |=> !shutdown_event_flag ##1 !o_shutdown_active)
        else $error("flag did not clear itself after shutdown went away");

    a_hold_until_sw: assert property (
        (shutdown_event_flag && !auto_restart && !wr_status)
        |=> shutdown_event_flag)
        else $error("flag cleared without software");

    a_set_wins_clear: assert property (
        sd_sync |=> shutdown_event_flag)
        else $error("shutdown event lost");

    // pin a inverts with mode bit 1; the level is judged against the mode seen at launch
    a_shut_pin_idle: assert property (
        (shutdown_event_flag && steer_mode && steer_act[0])
        |=> o_pin_out[0] == $past(capture_compare_mode_select[1]) && o_pin_oe[0])
        else $error("pin a not at inactive level in shutdown");

    a_sync_hold_steer: assert property (
        (steer_update_sync && !i_period_start) |=> $stable(steer_act))
        else $error("steering changed outside period start");

    a_tick_load_steer: assert property (
        (!steer_update_sync && tick) |=> steer_act == $past(steer_shadow))
        else $error("steering not applied at instruction boundary");

    a_steer_drives_pin: assert property (
        (steer_mode && steer_act[1] && !shutdown_event_flag && dbus.delayed)
        |=> o_pin_oe[1] && o_pin_out[1] == !$past(capture_compare_mode_select[0]))
        else $error("steered pin b wrong");

    a_release_to_port: assert property (
        (steer_mode && !steer_act[2])
        |=> o_pin_oe[2] == $past(i_port_oe[2]) && o_pin_out[2] == $past(i_port_data[2]))
        else $error("unsteered pin c not released");

    a_steer_upper_zero: assert property (
        (i_rd && i_addr == REG_STEER) |=> o_rd_data[7:5] == 3'h0)
        else $error("steering upper bits not zero");

    // reset edge excluded: the pin flops are still forced low there
    a_no_pwm_release: assert property (
        (!i_rst && !pwm_mode) |=> o_pin_oe == $past(i_port_oe))
        else $error("pins held outside pwm mode");

    c_auto_restart: cover property (
        shutdown_event_flag && auto_restart ##1 !shutdown_event_flag);

    c_period_update: cover property (
        steer_update_sync && i_period_start && steer_act != steer_shadow);

    c_sw_clear: cover property (
        shutdown_event_flag && wr_status && !i_wr_data[FLAG_BIT]);
endmodule // prs_top
`default_nettype wire

// [bench/prs_load.sv]
// load model for the four pwm output pins
// assumes pin values and enables from the output stage, pull-downs on every pin
`timescale 1ns/100ps
`default_nettype none
module prs_load
    import prs_pkg::*;
(
    input  wire logic [prs_pkg::NPIN-1:0] i_pin_out,
    input  wire logic [prs_pkg::NPIN-1:0] i_pin_oe,
    output var  logic [prs_pkg::NPIN-1:0] o_pin_level
);
    // a released pin sinks to its pull-down level
    always_comb
    begin
        for (int i = 0; i < NPIN; i++)
        begin
            o_pin_level[i] = i_pin_oe[i] ? i_pin_out[i] : 1'b0;
        end
    end
endmodule // prs_load
`default_nettype wire

// [bench/tb.sv]
// self-checking bench of the pwm restart, dead-band and steering stage
// assumes prs_pkg, the design files and prs_load compiled before it
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb;
    import prs_pkg::*;
    logic            i_ref_clk      = 1'b0;
    logic            i_rst          = 1'b1;
    logic [AW-1:0]   i_addr         = '0;
    logic [DW-1:0]   i_wr_data      = '0;
    logic            i_wr           = 1'b0;
    logic            i_rd           = 1'b0;
    logic            i_pwm_raw      = 1'b0;
    logic            i_period_start = 1'b0;
    logic            i_shutdown     = 1'b0;
    logic [NPIN-1:0] i_port_data    = 4'hF;
    logic [NPIN-1:0] i_port_oe      = 4'hA;
    logic [DW-1:0]   o_rd_data;
    logic [NPIN-1:0] o_pin_out;
    logic [NPIN-1:0] o_pin_oe;
    logic            o_shutdown_active;
    logic [NPIN-1:0] pin_level;
    int              bad_count = 0;
    int              n_tests   = 0;
    int              dly_tab [4] = '{0, 1, 2, 127};

    prs_top dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .i_pwm_raw(i_pwm_raw),
        .i_period_start(i_period_start), .i_shutdown(i_shutdown),
        .i_port_data(i_port_data), .i_port_oe(i_port_oe), .o_rd_data(o_rd_data),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_shutdown_active(o_shutdown_active));
    prs_load load_u (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .o_pin_level(pin_level));

    // 40 MHz clock
    always #12.5 i_ref_clk = ~i_ref_clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge i_ref_clk);
        i_wr      <= 1'b1;
        i_addr    <= a;
        i_wr_data <= d;
        @(posedge i_ref_clk);
        i_wr      <= 1'b0;
    endtask

    // read strobe for one cycle, data judged in the cycle after
    task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd   <= 1'b0;
        #1;
        `CHK(o_rd_data, exp)
    endtask

    task automatic raw(input logic v);
        @(posedge i_ref_clk);
        i_pwm_raw <= v;
    endtask

    task automatic t_regs;
        rd_chk(REG_DEADBAND, DEADBAND_RST);
        rd_chk(REG_STEER, STEER_RST);
        rd_chk(REG_MODE, MODE_RST);
        rd_chk(REG_STATUS, 8'h00);
        wr(REG_STEER, 8'hFF);
        rd_chk(REG_STEER, 8'h1F);
        wr(REG_DEADBAND, 8'hD5);
        rd_chk(REG_DEADBAND, 8'hD5);
        wr(REG_DEADBAND, 8'h00);
        wr(REG_STEER, 8'h01);
        $display("test regs done");
    endtask

    task automatic t_steer;
        raw(1'b1);
        cyc(8);
        `CHK(pin_level, 4'hA)
        wr(REG_MODE, 8'h0C);
        wr(REG_STEER, 8'h05);
        cyc(8);
        `CHK(o_pin_oe, 4'hF)
        `CHK(pin_level, 4'hF)
        raw(1'b0);
        cyc(4);
        `CHK(pin_level, 4'hA)
        wr(REG_MODE, 8'h0E);
        cyc(4);
        `CHK(pin_level, 4'hF)
        wr(REG_MODE, 8'h1C);
        raw(1'b1);
        cyc(8);
        `CHK(o_pin_oe, 4'hB)
        `CHK(pin_level, 4'hB)
        wr(REG_MODE, 8'h0C);
        $display("test steer done");
    endtask

    task automatic t_sync;
        wr(REG_STEER, 8'h12);
        cyc(10);
        `CHK(o_pin_oe, 4'hF)
        @(posedge i_ref_clk);
        i_period_start <= 1'b1;
        @(posedge i_ref_clk);
        i_period_start <= 1'b0;
        cyc(2);
        `CHK(o_pin_oe, 4'hA)
        `CHK(pin_level, 4'hA)
        // pin b alone carries high pwm; mode bit 0 inverts it
        wr(REG_MODE, 8'h0D);
        cyc(2);
        `CHK(pin_level, 4'h8)
        wr(REG_MODE, 8'h0C);
        wr(REG_STEER, 8'h05);
        cyc(6);
        `CHK(o_pin_oe, 4'hF)
        $display("test sync done");
    endtask

    // edges from the sampled raw rise to the active pin
    task automatic t_dead;
        int cnt;
        foreach (dly_tab[k])
        begin
            raw(1'b0);
            wr(REG_DEADBAND, 8'(dly_tab[k]));
            cyc(12);
            raw(1'b1);
            cnt = 0;
            while (pin_level[0] !== 1'b1 && cnt < 600)
            begin
                cyc(1);
                cnt++;
            end
            `CHK(cnt, 4 * dly_tab[k] + 2)
            raw(1'b0);
            cyc(2);
            `CHK(pin_level[0], 1'b0)
        end
        wr(REG_DEADBAND, 8'h00);
        $display("test deadband done");
    endtask

    task automatic shut(input logic v);
        @(posedge i_ref_clk);
        i_shutdown <= v;
    endtask

    task automatic t_shut;
        raw(1'b1);
        cyc(6);
        shut(1'b1);
        cyc(5);
        `CHK(o_shutdown_active, 1'b1)
        `CHK(pin_level[0], 1'b0)
        shut(1'b0);
        cyc(8);
        `CHK(o_shutdown_active, 1'b1)
        rd_chk(REG_STATUS, 8'h01);
        `CHK(pin_level[0], 1'b0)
        wr(REG_STATUS, 8'h00);
        cyc(4);
        `CHK(o_shutdown_active, 1'b0)
        `CHK(pin_level[0], 1'b1)
        wr(REG_DEADBAND, 8'h80);
        shut(1'b1);
        cyc(5);
        `CHK(o_shutdown_active, 1'b1)
        shut(1'b0);
        cyc(6);
        `CHK(o_shutdown_active, 1'b0)
        `CHK(pin_level[0], 1'b1)
        $display("test shutdown done");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        t_regs();
        t_steer();
        t_sync();
        t_dead();
        t_shut();
        results();
    end

    // watchdog, far beyond the expected run of under a thousand cycles
    initial
    begin
        #(25 * 20000);
        bad_count++;
        results();
    end
endmodule // tb
`default_nettype wire
